// ---- csc_pkg.sv ----
// constants and types shared by the channel sequence configuration block
package csc_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] idx_tick_count = 8'h08;
    localparam logic [7:0] idx_chan_first = 8'h09;
    localparam logic [7:0] idx_chan_last = 8'h18;
    localparam logic [7:0] idx_control = 8'h40;
    localparam logic [7:0] idx_status = 8'h41;
    localparam logic [7:0] idx_sequence = 8'h42;
    localparam logic [7:0] idx_limits = 8'h43;

    // channel register fields
    localparam int chan_enable_bit = 23;
    localparam int setup_hi = 22;
    localparam int setup_lo = 20;
    localparam int switch_bit = 19;
    localparam int monitor_bit = 18;
    localparam int input_hi = 17;
    localparam int input_lo = 13;

    localparam logic [23:0] chan0_reset = 24'h800100;
    localparam logic [23:0] chan_reset = 24'h000100;
    localparam logic [7:0] tick_reset = 8'h00;

    // control register bits
    localparam int ctl_tick_enable = 0;
    localparam int ctl_standby_allow = 1;
    localparam int ctl_fifo_enable = 2;
    localparam int ctl_run = 3;

    // main clock prescaler
    localparam logic [7:0] prescale_last = 8'd130;

    typedef enum logic [1:0] {
        csc_active,
        csc_standby,
        csc_powerdown
    } csc_power_t;
endpackage : csc_pkg

// ---- csc_top.sv ----
// channel sequence configuration registers, sequencer and main-clock tick counter
module csc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic main_clk_pulse,
    input wire logic result_done,
    input wire logic [15:0] result_data,
    input wire csc_pkg::csc_power_t power_state,
    output logic [3:0] conv_channel,
    output logic [2:0] conv_setup,
    output logic [4:0] positive_input_select,
    output logic low_side_switch_enable,
    output logic conv_active,
    output logic limit_flag
);
    logic [23:0] chan_cfg [16];
    logic [7:0] tick_count;
    logic [7:0] prescale;
    logic [3:0] ctl;
    logic [3:0] status_channel;
    logic [15:0] lower_limit_value;
    logic [15:0] upper_limit_value;
    logic [3:0] cur_chan;
    logic [7:0] reg_idx;
    logic access;
    logic wr;
    logic mapped;
    logic any_enabled;
    logic [3:0] next_chan;
    logic [31:0] next_rdata;

    // next enabled channel above cur, wrapping to the lowest enabled one
    function automatic logic [3:0] csc_next_enabled(input logic [15:0] en, input logic [3:0] cur);
        logic [3:0] pick;
        logic found;
        logic [3:0] c;
        pick = cur;
        found = 1'b0;
        for (int i = 1; i <= 16; i++) begin
            c = 4'(int'(cur) + i);
            if (!found && en[c]) begin
                pick = c;
                found = 1'b1;
            end
        end
        return pick;
    endfunction : csc_next_enabled

    // index decode used by both read and write paths
    function automatic logic csc_is_chan(input logic [7:0] idx);
        return idx >= csc_pkg::idx_chan_first && idx <= csc_pkg::idx_chan_last;
    endfunction : csc_is_chan

    logic [15:0] enables;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            enables[i] = chan_cfg[i][csc_pkg::chan_enable_bit];
        end
    end

    assign reg_idx = paddr[9:2];
    assign access = psel && penable;
    assign wr = access && pwrite && pready;
    assign any_enabled = |enables;
    assign next_chan = csc_next_enabled(enables, cur_chan);
    assign mapped = paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00
        && (reg_idx == csc_pkg::idx_tick_count || csc_is_chan(reg_idx)
        || (reg_idx >= csc_pkg::idx_control && reg_idx <= csc_pkg::idx_limits));

    // channel registers; ownership of a setup value is not exclusive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_cfg[0] <= csc_pkg::chan0_reset;
            for (int i = 1; i < 16; i++) begin
                chan_cfg[i] <= csc_pkg::chan_reset;
            end
        end else if (wr && csc_is_chan(reg_idx)) begin
            chan_cfg[4'(reg_idx - csc_pkg::idx_chan_first)] <= pwdata[23:0];
        end
    end

    // control and limit registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= 4'h0;
            lower_limit_value <= 16'h0000;
            upper_limit_value <= 16'hffff;
        end else if (wr && reg_idx == csc_pkg::idx_control) begin
            ctl <= pwdata[3:0];
        end else if (wr && reg_idx == csc_pkg::idx_limits) begin
            lower_limit_value <= pwdata[15:0];
            upper_limit_value <= pwdata[31:16];
        end
    end

    // prescaler and tick counter; a bus write to the count index is ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= 8'h00;
            tick_count <= csc_pkg::tick_reset;
        end else if (ctl[csc_pkg::ctl_tick_enable] && main_clk_pulse) begin
            if (prescale == csc_pkg::prescale_last) begin
                prescale <= 8'h00;
                tick_count <= tick_count + 8'h01;
            end else begin
                prescale <= prescale + 8'h01;
            end
        end
    end

    // sequencer: a result completes the current channel and moves on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_chan <= 4'h0;
            status_channel <= 4'h0;
        end else if (!any_enabled) begin
            cur_chan <= 4'h0;
        end else if (!enables[cur_chan]) begin
            cur_chan <= next_chan; // resync if current channel got disabled
        end else if (result_done && ctl[csc_pkg::ctl_run]) begin
            status_channel <= cur_chan;
            cur_chan <= next_chan;
        end
    end

    // per-conversion outputs drawn from the active channel's register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_channel <= 4'h0;
            conv_setup <= 3'h0;
            positive_input_select <= 5'h00;
            low_side_switch_enable <= 1'b0;
            conv_active <= 1'b0;
        end else begin
            conv_channel <= cur_chan;
            conv_setup <= chan_cfg[cur_chan][csc_pkg::setup_hi:csc_pkg::setup_lo];
            positive_input_select <= chan_cfg[cur_chan][csc_pkg::input_hi:csc_pkg::input_lo];
            conv_active <= ctl[csc_pkg::ctl_run] && enables[cur_chan]
                && power_state == csc_pkg::csc_active;
            // switch stays closed in standby only when explicitly allowed
            low_side_switch_enable <= chan_cfg[cur_chan][csc_pkg::switch_bit]
                && ctl[csc_pkg::ctl_run] && enables[cur_chan]
                && (power_state == csc_pkg::csc_active
                || (power_state == csc_pkg::csc_standby
                && ctl[csc_pkg::ctl_standby_allow]));
        end
    end

    // limit monitor, sticky until the status register is written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_flag <= 1'b0;
        end else if (result_done && ctl[csc_pkg::ctl_run] && enables[cur_chan]
                && ctl[csc_pkg::ctl_fifo_enable] && chan_cfg[cur_chan][csc_pkg::monitor_bit]
                && (result_data < lower_limit_value || result_data > upper_limit_value)) begin
            limit_flag <= 1'b1;
        end else if (wr && reg_idx == csc_pkg::idx_status) begin
            limit_flag <= 1'b0;
        end
    end

    // read mux
    always_comb begin
        next_rdata = 32'h00000000;
        if (reg_idx == csc_pkg::idx_tick_count) begin
            next_rdata = {24'h000000, tick_count};
        end else if (csc_is_chan(reg_idx)) begin
            next_rdata = {8'h00, chan_cfg[4'(reg_idx - csc_pkg::idx_chan_first)]};
        end else if (reg_idx == csc_pkg::idx_control) begin
            next_rdata = {28'h0000000, ctl};
        end else if (reg_idx == csc_pkg::idx_status) begin
            next_rdata = {23'h000000, limit_flag, cur_chan, status_channel};
        end else if (reg_idx == csc_pkg::idx_sequence) begin
            next_rdata = {16'h0000, enables};
        end else if (reg_idx == csc_pkg::idx_limits) begin
            next_rdata = {upper_limit_value, lower_limit_value};
        end
    end

    // apb answer: no wait state, pready and data both come from flops loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= (mapped && !pwrite) ? next_rdata : 32'h00000000;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end
endmodule : csc_top

// ---- csc_top_sva.sv ----
// port assertions for the channel sequence configuration block
module csc_top_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire csc_pkg::csc_power_t power_state,
    input wire logic low_side_switch_enable,
    input wire logic conv_active
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // setup cycle and word index seen by the slave
    wire logic setup_now = psel && !penable;
    wire logic [7:0] idx = paddr[9:2];
    ready_first_a: assert property (setup_now |=> pready) else $error("no ready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    read_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("data when idle");
    tick_width_a: assert property (pready && idx == 8'h08 |-> prdata[31:8] == 24'h0)
        else $error("count too wide");
    chan_width_a: assert property (pready && idx inside {[8'h09:8'h18]} |-> prdata[31:24] == 8'h0)
        else $error("channel too wide");
    chan_noerr_a: assert property (setup_now && idx inside {[8'h08:8'h18]} |=> !pslverr)
        else $error("error on mapped");
    unmapped_err_a: assert property (setup_now && idx > 8'h43 |=> pslverr)
        else $error("no error on unmapped");
    switch_off_a: assert property (power_state == csc_pkg::csc_powerdown |=> !low_side_switch_enable)
        else $error("switch closed in power-down");
    active_off_a: assert property (power_state != csc_pkg::csc_active |=> !conv_active)
        else $error("converting while not active");
    // main scenarios reached
    cover property (pslverr);
    cover property (low_side_switch_enable);
    cover property (pready && idx == 8'h08);
endmodule : csc_top_sva

bind csc_top csc_top_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_state(power_state),
    .low_side_switch_enable(low_side_switch_enable), .conv_active(conv_active));

// ---- csc_adc_model.sv ----
// converter-side model: main-clock pulses and conversion results
module csc_adc_model (
    input wire logic pclk,
    output logic main_clk_pulse,
    output logic result_done,
    output logic [15:0] result_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial main_clk_pulse = 1'b0;
    initial result_done = 1'b0;
    initial result_data = 16'h1234;
    // pulse then gap, since the main clock is far slower than pclk
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge pclk);
            main_clk_pulse <= 1'b1;
            @(posedge pclk);
            main_clk_pulse <= 1'b0;
        end
    endtask : pulses
    // one result, then time for the sequencer to move on
    task automatic result();
        @(posedge pclk);
        result_done <= 1'b1;
        @(posedge pclk);
        result_done <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : result
endmodule : csc_adc_model

// ---- test_csc_top.sv ----
// self-checking bench for the channel sequence configuration block
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module test_csc_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, main_clk_pulse, result_done, low_side_switch_enable, conv_active;
    logic limit_flag;
    logic [15:0] result_data;
    csc_pkg::csc_power_t power_state = csc_pkg::csc_active;
    logic [3:0] conv_channel;
    logic [2:0] conv_setup;
    logic [4:0] positive_input_select;
    int n_fail = 0, checked = 0;
    csc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .main_clk_pulse, .result_done, .result_data, .power_state, .conv_channel,
        .conv_setup, .positive_input_select, .low_side_switch_enable, .conv_active, .limit_flag);
    csc_adc_model adc (.pclk, .main_clk_pulse, .result_done, .result_data);
    initial forever #20 pclk = ~pclk;
    // one apb transfer; result lands in rd and err
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic tick_is(input logic [31:0] exp);
        apb(1'b0, csc_pkg::idx_tick_count, 32'h0);
        `CHK("tick", exp, rd)
    endtask : tick_is
    task automatic t_reset();
        tick_is(32'h0);
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, csc_pkg::idx_chan_first + 8'(i), 32'h0);
            `CHK("chan", (i == 0) ? 32'h800100 : 32'h000100, rd)
        end
        apb(1'b0, csc_pkg::idx_sequence, 32'h0);
        `CHK("map", 32'h1, rd)
        $display("t_reset done");
    endtask : t_reset
    task automatic t_tick();
        apb(1'b1, csc_pkg::idx_control, 32'h1);
        adc.pulses(3 * 131);
        tick_is(32'h3);
        adc.pulses(130);
        tick_is(32'h3);
        adc.pulses(1);
        tick_is(32'h4);
        apb(1'b1, csc_pkg::idx_tick_count, 32'h55);
        tick_is(32'h4);
        adc.pulses(252 * 131);
        tick_is(32'h0);
        apb(1'b1, csc_pkg::idx_control, 32'h0);
        adc.pulses(131);
        tick_is(32'h0);
        $display("t_tick done");
    endtask : t_tick
    task automatic t_seq();
        logic [3:0] nxt [3] = '{4'h3, 4'h5, 4'h0};
        logic [3:0] last [3] = '{4'h0, 4'h3, 4'h5};
        logic [2:0] stp [3] = '{3'h5, 3'h5, 3'h0};
        logic [4:0] inp [3] = '{5'h07, 5'h02, 5'h00};
        logic [2:0] sw = 3'b001;
        apb(1'b1, csc_pkg::idx_chan_first + 8'h3, 32'h00d8e000); // enabled, setup 5, switch
        apb(1'b1, csc_pkg::idx_chan_first + 8'h5, 32'h00d04000); // shares setup 5
        apb(1'b1, csc_pkg::idx_control, 32'h8);
        for (int k = 0; k < 3; k++) begin
            adc.result();
            `CHK("next", nxt[k], conv_channel)
            `CHK("setup", stp[k], conv_setup)
            `CHK("input", inp[k], positive_input_select)
            `CHK("switch", sw[k], low_side_switch_enable)
            `CHK("active", 1'b1, conv_active)
            apb(1'b0, csc_pkg::idx_status, 32'h0);
            `CHK("status", last[k], rd[3:0])
        end
        adc.result();
        power_state <= csc_pkg::csc_powerdown;
        repeat (3) @(posedge pclk);
        `CHK("pd switch", 1'b0, low_side_switch_enable)
        power_state <= csc_pkg::csc_standby;
        repeat (3) @(posedge pclk);
        `CHK("sb switch", 1'b0, low_side_switch_enable)
        apb(1'b1, csc_pkg::idx_control, 32'ha);
        repeat (2) @(posedge pclk);
        `CHK("sb allow", 1'b1, low_side_switch_enable)
        power_state <= csc_pkg::csc_active;
        $display("t_seq done");
    endtask : t_seq
    // limit monitor: gated by the fifo enable, sticky until the status index is written
    task automatic t_limit();
        apb(1'b1, csc_pkg::idx_limits, 32'h10000000); // upper 0x1000, model result above it
        apb(1'b1, csc_pkg::idx_chan_first, 32'h00840100);
        apb(1'b1, csc_pkg::idx_chan_first + 8'h3, 32'h00dce000);
        apb(1'b1, csc_pkg::idx_chan_first + 8'h5, 32'h00d44000);
        adc.result();
        apb(1'b0, csc_pkg::idx_status, 32'h0);
        `CHK("lim off", 1'b0, rd[8])
        apb(1'b1, csc_pkg::idx_control, 32'he);
        adc.result();
        `CHK("lim port", 1'b1, limit_flag)
        apb(1'b0, csc_pkg::idx_status, 32'h0);
        `CHK("lim on", 1'b1, rd[8])
        apb(1'b1, csc_pkg::idx_status, 32'h0);
        apb(1'b0, csc_pkg::idx_status, 32'h0);
        `CHK("lim clr", 1'b0, rd[8])
        $display("t_limit done");
    endtask : t_limit
    task automatic t_err();
        apb(1'b0, 8'h30, 32'h0);
        `CHK("err", 1'b1, err)
        `CHK("err data", 32'h0, rd)
        $display("t_err done");
    endtask : t_err
    task automatic stop_test();
        $display("checks %0d fails %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    // main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tick();
        t_seq();
        t_limit();
        t_err();
        stop_test();
    end
    // watchdog: the wrap test alone needs about 66k cycles
    initial begin
        repeat (90000) @(posedge pclk);
        n_fail++;
        stop_test();
    end
endmodule : test_csc_top
